// ===== verilog/ppim_pkg.sv
// constants shared by the printer port and interrupt multiplexer
package ppim_pkg;
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_DATA    = 4'h4;
  localparam logic [3:0]  OFS_STATUS  = 4'h8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int          CTRL_W      = 9;
  localparam int          CB_LATCH    = 0;
  localparam int          CB_ADVANCE  = 1;
  localparam int          CB_SETUP    = 2;
  localparam int          CB_CHOOSE   = 3;
  localparam int          CB_IRQ_EN   = 4;
  localparam int          CB_ENHANCED = 5;
  localparam int          CB_STANDALN = 6;
  localparam int          CB_SER0_EN  = 7;
  localparam int          CB_SER1_EN  = 8;
  localparam logic [8:0]  CTRL_RESET  = 9'h000;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  // ---------------------------------------------------------------
  // printer input vector and status fields
  // ---------------------------------------------------------------
  localparam int          PIN_W       = 6;
  localparam int          PB_ERROR    = 0;
  localparam int          PB_ONLINE   = 1;
  localparam int          PB_BUSY     = 2;
  localparam int          PB_NOMEDIA  = 3;
  localparam int          PB_CONFIRM  = 4;
  localparam int          PB_IRQLINE  = 5;
  localparam int          SB_PENDING  = 5;
  // ---------------------------------------------------------------
  // multiplexer
  // ---------------------------------------------------------------
  localparam int          REQ_W       = 11;
  localparam int          SLOT_W      = 3;
  localparam int          MUXIN_W     = 18;
  localparam int          SYNC_STAGES = 3;
endpackage : ppim_pkg

// ===== verilog/ppim_mux_if.sv
// signals between the port core and the interrupt multiplexer
`timescale 1ns/10ps
interface ppim_mux_if;
  logic [2:0]  slotCode;
  logic [10:0] req;
  logic        irqLineIn;
  logic        resetReq;
  logic        narrowBoot;
  logic        kbdIrq;
  logic        highGate;
  logic        standalone;
  logic [1:0]  serialIrq;
  logic [1:0]  serialEn;
  logic        set0;
  logic        set1;
  logic        set0Oe;
  logic        set1Oe;
  modport core (output slotCode, req, irqLineIn, resetReq, narrowBoot, kbdIrq, highGate,
                output standalone, serialIrq, serialEn, input set0, set1, set0Oe, set1Oe);
  modport mux  (input slotCode, req, irqLineIn, resetReq, narrowBoot, kbdIrq, highGate,
                input standalone, serialIrq, serialEn, output set0, set1, set0Oe, set1Oe);
endinterface : ppim_mux_if

// ===== verilog/ppim_sync.sv
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/10ps
module ppim_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         mclk_en,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ppim_sync_state_t;

  ppim_sync_state_t st_reg;
  ppim_sync_state_t st_next;

  // shift chain, output follows only settled bits
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = asyncIn;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (mclk_en) begin
      st_reg <= st_next;
    end
  end

  assign syncOut = st_reg.q;
endmodule : ppim_sync

// ===== verilog/ppim_irq_mux.sv
// interrupt multiplexer: slot-coded pairs onto two set outputs
`timescale 1ns/10ps
module ppim_irq_mux (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  mclk_en,
  ppim_mux_if.mux    mx
);
  typedef struct packed {
    logic set0;
    logic set1;
    logic set0Oe;
    logic set1Oe;
  } ppim_mux_state_t;

  ppim_mux_state_t st_reg;
  ppim_mux_state_t st_next;
  logic [7:0]      lane0;
  logic [7:0]      lane1;

  // pick one of eight lane entries by slot code
  function automatic logic pickSlot(input logic [2:0] slot, input logic [7:0] lane);
    pickSlot = lane[slot];
  endfunction : pickSlot

  // lane 0: requests 3,4,5,6, printer line, 8,9,10; lane 1: 11,14,15,12, flags
  assign lane0 = {mx.req[6:4], mx.irqLineIn, mx.req[3:0]};
  assign lane1 = {mx.highGate, mx.kbdIrq, mx.narrowBoot, mx.resetReq, mx.req[10:7]};

  // standalone turns the set pins into serial interrupt drivers
  always_comb begin
    st_next = st_reg;
    if (mx.standalone) begin
      st_next.set0   = mx.serialIrq[0];
      st_next.set1   = mx.serialIrq[1];
      st_next.set0Oe = mx.serialEn[0];
      st_next.set1Oe = mx.serialEn[1];
    end else begin
      st_next.set0   = pickSlot(mx.slotCode, lane0);
      st_next.set1   = pickSlot(mx.slotCode, lane1);
      st_next.set0Oe = 1'b1;
      st_next.set1Oe = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (mclk_en) begin
      st_reg <= st_next;
    end
  end

  assign mx.set0   = st_reg.set0;
  assign mx.set1   = st_reg.set1;
  assign mx.set0Oe = st_reg.set0Oe;
  assign mx.set1Oe = st_reg.set1Oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_slot_narrow_boot: assert property (
    (mclk_en && !mx.standalone && mx.slotCode == 3'h5) |=> (mx.set1 == $past(mx.narrowBoot)))
    else $error("narrow boot flag not on set output 1 in slot 5");
  a_slot_irq_line: assert property (
    (mclk_en && !mx.standalone && mx.slotCode == 3'h4) |=> (mx.set0 == $past(mx.irqLineIn)))
    else $error("printer line not sampled in slot 4");
  a_standalone_serial: assert property (
    (mclk_en && mx.standalone) |=> (mx.set0 == $past(mx.serialIrq[0])
                                    && mx.set1Oe == $past(mx.serialEn[1])))
    else $error("standalone set outputs not serial interrupts");
  c_slot_seven: cover property (mclk_en && !mx.standalone && mx.slotCode == 3'h7);
endmodule : ppim_irq_mux

// ===== verilog/ppim_printer_port.sv
// printer-side port signalling with interrupt multiplexer, AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module ppim_printer_port (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        mclk_en,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic [7:0]       printerDataBus,
  output logic             printerLatchPulse,
  output logic             autoLineAdvance,
  output logic             printerSetupRequest,
  output logic             printerChooseOut,
  input  wire logic        printerErrorIn,
  input  wire logic        printerOnlineIn,
  input  wire logic        printerBusyIn,
  input  wire logic        noMediaIn,
  input  wire logic        printerConfirmIn,
  input  wire logic        printerIrqLineIn,
  output logic             printerIrqLineOut,
  output logic             printerIrqLineOe,
  input  wire logic [2:0]  muxSlotCode,
  input  wire logic [10:0] irqRequestIn,
  input  wire logic        processorResetRequest,
  input  wire logic        narrowBootFlag,
  input  wire logic        keyboardIrqFlag,
  input  wire logic        highAddressGate,
  input  wire logic [1:0]  serialIrqIn,
  output logic             muxSetOut0,
  output logic             muxSetOut0Oe,
  output logic             muxSetOut1,
  output logic             muxSetOut1Oe
);
  typedef struct packed {
    logic [8:0]  ctrl;
    logic [7:0]  data;
    logic        irqPending;
    logic        confirmPrev;
    logic        awReady;
    logic        awHave;
    logic [3:0]  awAddr;
    logic        wReady;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [1:0]  rResp;
    logic [31:0] rData;
    logic        latchOut;
    logic        advOut;
    logic        setupOut;
    logic        chooseOut;
    logic [7:0]  dataOut;
    logic        irqOut;
    logic        irqOe;
  } ppim_port_state_t;

  ppim_port_state_t st_reg;
  ppim_port_state_t st_next;
  logic [5:0]       pinSync;
  logic [17:0]      muxSync;
  logic             confirmRise;
  logic             confirmFall;
  logic             wrFire;
  logic             dataWr;
  logic             statusRead;
  logic [1:0]       serialSync;

  ppim_mux_if mxIf ();

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  ppim_sync #(.W(ppim_pkg::PIN_W)) uPinSync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mclk_en (mclk_en),
    .asyncIn ({printerIrqLineIn, printerConfirmIn, noMediaIn, printerBusyIn,
               printerOnlineIn, printerErrorIn}),
    .syncOut (pinSync)
  );

  ppim_sync #(.W(ppim_pkg::MUXIN_W)) uMuxSync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mclk_en (mclk_en),
    .asyncIn ({muxSlotCode, highAddressGate, keyboardIrqFlag, narrowBootFlag,
               processorResetRequest, irqRequestIn}),
    .syncOut (muxSync)
  );

  ppim_sync #(.W(2)) uSerSync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mclk_en (mclk_en),
    .asyncIn (serialIrqIn),
    .syncOut (serialSync)
  );

  // ---------------------------------------------------------------
  // multiplexer hookup
  // ---------------------------------------------------------------
  // the irq line is only a mux input while it is not being driven
  assign mxIf.req        = muxSync[10:0];
  assign mxIf.resetReq   = muxSync[11];
  assign mxIf.narrowBoot = muxSync[12];
  assign mxIf.kbdIrq     = muxSync[13];
  assign mxIf.highGate   = muxSync[14];
  assign mxIf.slotCode   = muxSync[17:15];
  assign mxIf.irqLineIn  = pinSync[ppim_pkg::PB_IRQLINE] & ~st_reg.irqOe;
  assign mxIf.standalone = st_reg.ctrl[ppim_pkg::CB_STANDALN];
  assign mxIf.serialIrq  = serialSync;
  assign mxIf.serialEn   = st_reg.ctrl[ppim_pkg::CB_SER1_EN:ppim_pkg::CB_SER0_EN];

  ppim_irq_mux uMux (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mclk_en (mclk_en),
    .mx      (mxIf.mux)
  );

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  // true for a mapped word address
  function automatic logic addrMapped(input logic [3:0] a);
    addrMapped = (a == ppim_pkg::OFS_CTRL) || (a == ppim_pkg::OFS_DATA)
              || (a == ppim_pkg::OFS_STATUS);
  endfunction : addrMapped

  // next state: bus slave, control, interrupt and pin drivers
  always_comb begin
    st_next     = st_reg;
    confirmRise = pinSync[ppim_pkg::PB_CONFIRM] && !st_reg.confirmPrev;
    confirmFall = !pinSync[ppim_pkg::PB_CONFIRM] && st_reg.confirmPrev;
    st_next.confirmPrev = pinSync[ppim_pkg::PB_CONFIRM];
    wrFire      = st_reg.awHave && st_reg.wHave;
    dataWr      = wrFire && st_reg.awAddr == ppim_pkg::OFS_DATA && st_reg.wStrb[0];
    statusRead  = arvalid && st_reg.arReady && araddr == ppim_pkg::OFS_STATUS;
    // address and data channels, taken in either order
    if (awvalid && st_reg.awReady) begin
      st_next.awHave = 1'b1;
      st_next.awAddr = awaddr;
    end
    if (wvalid && st_reg.wReady) begin
      st_next.wHave = 1'b1;
      st_next.wData = wdata;
      st_next.wStrb = wstrb;
    end
    if (wrFire) begin
      st_next.awHave = 1'b0;
      st_next.wHave  = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp  = addrMapped(st_reg.awAddr) ? ppim_pkg::RESP_OKAY
                                                 : ppim_pkg::RESP_SLVERR;
      if (st_reg.awAddr == ppim_pkg::OFS_CTRL) begin
        if (st_reg.wStrb[0]) begin
          st_next.ctrl[7:0] = st_reg.wData[7:0];
        end
        if (st_reg.wStrb[1]) begin
          st_next.ctrl[8] = st_reg.wData[8];
        end
      end
      if (dataWr) begin
        st_next.data = st_reg.wData[7:0];
      end
    end
    if (st_reg.bValid && bready) begin
      st_next.bValid = 1'b0;
    end
    st_next.awReady = !st_next.awHave && !st_next.bValid;
    st_next.wReady  = !st_next.wHave && !st_next.bValid;
    // read channel
    if (arvalid && st_reg.arReady) begin
      st_next.rValid = 1'b1;
      st_next.rResp  = addrMapped(araddr) ? ppim_pkg::RESP_OKAY : ppim_pkg::RESP_SLVERR;
      st_next.rData  = 32'h0000_0000;
      unique case (araddr)
        ppim_pkg::OFS_CTRL:   st_next.rData[8:0] = st_reg.ctrl;
        ppim_pkg::OFS_DATA:   st_next.rData[7:0] = st_reg.data;
        ppim_pkg::OFS_STATUS: st_next.rData[5:0] = {st_reg.irqPending, pinSync[4:0]};
        default:              st_next.rData      = 32'h0000_0000;
      endcase
    end
    if (st_reg.rValid && rready) begin
      st_next.rValid = 1'b0;
    end
    st_next.arReady = !st_next.rValid;
    // printer interrupt; a new confirm edge beats a clearing read
    if (!st_reg.ctrl[ppim_pkg::CB_ENHANCED]) begin
      if (confirmRise) begin
        st_next.irqPending = 1'b1;
      end else if (confirmFall) begin
        st_next.irqPending = 1'b0;
      end
    end else begin
      if (statusRead) begin
        st_next.irqPending = 1'b0;
      end
      if (confirmRise) begin
        st_next.irqPending = 1'b1;
      end
    end
    // printer controls; latch is held off while the byte changes
    st_next.dataOut   = st_next.data;
    st_next.latchOut  = st_next.ctrl[ppim_pkg::CB_LATCH] && !dataWr;
    st_next.advOut    = st_next.ctrl[ppim_pkg::CB_ADVANCE];
    st_next.setupOut  = st_next.ctrl[ppim_pkg::CB_SETUP];
    st_next.chooseOut = st_next.ctrl[ppim_pkg::CB_CHOOSE];
    st_next.irqOut    = st_reg.irqPending;
    st_next.irqOe     = st_reg.ctrl[ppim_pkg::CB_STANDALN]
                     && st_reg.ctrl[ppim_pkg::CB_IRQ_EN];
  end

  // state register; reset leaves the mux in non-standalone mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg      <= '0;
      st_reg.ctrl <= ppim_pkg::CTRL_RESET;
      st_reg.data <= ppim_pkg::DATA_RESET;
    end else if (mclk_en) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign awready             = st_reg.awReady;
  assign wready              = st_reg.wReady;
  assign bvalid              = st_reg.bValid;
  assign bresp               = st_reg.bResp;
  assign arready             = st_reg.arReady;
  assign rvalid              = st_reg.rValid;
  assign rdata               = st_reg.rData;
  assign rresp               = st_reg.rResp;
  assign printerDataBus      = st_reg.dataOut;
  assign printerLatchPulse   = st_reg.latchOut;
  assign autoLineAdvance     = st_reg.advOut;
  assign printerSetupRequest = st_reg.setupOut;
  assign printerChooseOut    = st_reg.chooseOut;
  assign printerIrqLineOut   = st_reg.irqOut;
  assign printerIrqLineOe    = st_reg.irqOe;
  assign muxSetOut0          = mxIf.set0;
  assign muxSetOut1          = mxIf.set1;
  assign muxSetOut0Oe        = mxIf.set0Oe;
  assign muxSetOut1Oe        = mxIf.set1Oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_latch_data_stable: assert property (
    $rose(printerLatchPulse) |-> $stable(printerDataBus))
    else $error("printer data changed as the latch rose");
  a_advance_follows: assert property (
    mclk_en |=> (autoLineAdvance == $past(st_next.ctrl[ppim_pkg::CB_ADVANCE])))
    else $error("advance output does not follow its bit");
  a_setup_follows: assert property (
    mclk_en |=> (printerSetupRequest == $past(st_next.ctrl[ppim_pkg::CB_SETUP])))
    else $error("setup output does not follow its bit");
  a_choose_follows: assert property (
    mclk_en |=> (printerChooseOut == $past(st_next.ctrl[ppim_pkg::CB_CHOOSE])))
    else $error("choose output does not follow its bit");
  a_irq_drive_gate: assert property (
    (mclk_en && !st_reg.ctrl[ppim_pkg::CB_IRQ_EN]) |=> !printerIrqLineOe)
    else $error("irq line driven with its enable clear");
  a_irq_drive_value: assert property (
    (mclk_en && printerIrqLineOe) |=> (printerIrqLineOut == $past(st_reg.irqPending)))
    else $error("driven irq line does not carry the port interrupt");
  a_legacy_irq_edges: assert property (
    (mclk_en && !st_reg.ctrl[ppim_pkg::CB_ENHANCED] && confirmFall) |=> !st_reg.irqPending)
    else $error("legacy interrupt not cleared on confirm fall");
  a_enh_irq_hold: assert property (
    (mclk_en && st_reg.ctrl[ppim_pkg::CB_ENHANCED] && st_reg.irqPending && !statusRead)
    |=> st_reg.irqPending)
    else $error("enhanced interrupt cleared without status read");
  a_irq_set_rise: assert property (
    (mclk_en && confirmRise) |=> st_reg.irqPending)
    else $error("confirm rise did not set the interrupt");
  a_reset_mode: assert property (
    $rose(rst_n) |-> (!st_reg.ctrl[ppim_pkg::CB_STANDALN] && !st_reg.ctrl[ppim_pkg::CB_ENHANCED]))
    else $error("reset left standalone mode on");
  c_legacy_cycle: cover property (confirmRise ##[1:40] confirmFall);
  c_enh_clear: cover property (st_reg.ctrl[ppim_pkg::CB_ENHANCED] && statusRead);
  c_latch_pulse: cover property ($rose(printerLatchPulse) ##[1:200] $fell(printerLatchPulse));
  c_standalone_drive: cover property (printerIrqLineOe && printerIrqLineOut);
endmodule : ppim_printer_port

// ===== tb/ppim_printer_model.sv
// line printer and system controller model on the far side of the port
`timescale 1ns/10ps
module ppim_printer_model (
  input  wire logic       mclk,
  input  wire logic       latchPulse,
  input  wire logic       chooseOut,
  input  wire logic [7:0] dataBus,
  input  wire logic       paperOut,
  input  wire logic [2:0] slotSel,
  output logic            errorIn,
  output logic            onlineIn,
  output logic            busyIn,
  output logic            noMediaIn,
  output logic            confirmIn,
  output logic [2:0]      slotCode,
  output logic [7:0]      gotByte
);
  // ----------------------------------------------------------
  // reply timing
  // ----------------------------------------------------------
  localparam int BUSY_CYC = 20;
  localparam int ACK_CYC  = 30;
  logic latchLast = 1'b0;
  int   ackCnt    = 0;
  // capture the byte at each latch rise, then busy, then confirm
  always @(posedge mclk) begin
    latchLast <= latchPulse;
    if (latchPulse && !latchLast) begin
      ackCnt  <= 1;
      gotByte <= dataBus;
    end else if (ackCnt != 0 && ackCnt < BUSY_CYC + ACK_CYC) begin
      ackCnt <= ackCnt + 1;
    end else begin
      ackCnt <= 0;
    end
  end
  // status lines seen by the port
  assign busyIn    = (ackCnt != 0) && (ackCnt <= BUSY_CYC);
  assign confirmIn = ackCnt > BUSY_CYC;
  assign onlineIn  = chooseOut;
  assign noMediaIn = paperOut;
  assign errorIn   = paperOut || !chooseOut;
  assign slotCode  = slotSel;
endmodule : ppim_printer_model

// ===== tb/ppim_printer_port_tb_top.sv
// self-checking bench for the printer port and interrupt multiplexer
`timescale 1ns/10ps
module ppim_printer_port_tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, paperOut = 1'b0, mclkEn = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, resp, serialIrqIn = 2'h0;
  logic [7:0]  v0 = 8'h00, v1 = 8'h00, printerDataBus, gotByte;
  logic [2:0]  slotSel = 3'h0, muxSlotCode;
  logic [10:0] irqRequestIn;
  logic        awready, wready, bvalid, arready, rvalid, printerLatchPulse, autoLineAdvance;
  logic        printerSetupRequest, printerChooseOut, printerErrorIn, printerOnlineIn;
  logic        printerBusyIn, noMediaIn, printerConfirmIn, printerIrqLineIn, printerIrqLineOut;
  logic        printerIrqLineOe, processorResetRequest, narrowBootFlag, keyboardIrqFlag;
  logic        highAddressGate, muxSetOut0, muxSetOut0Oe, muxSetOut1, muxSetOut1Oe;
  int          miscompares = 0, checksDone = 0;
  // request sources by slot lane, and the irq pin level from both drivers
  assign irqRequestIn = {v1[3:0], v0[7:5], v0[3:0]};
  assign {highAddressGate, keyboardIrqFlag, narrowBootFlag,
          processorResetRequest} = v1[7:4];
  assign printerIrqLineIn = printerIrqLineOe ? printerIrqLineOut : v0[4];
  ppim_printer_port u_ppim_printer_port (.mclk, .rst_n, .mclk_en(mclkEn), .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .printerDataBus, .printerLatchPulse,
    .autoLineAdvance, .printerSetupRequest, .printerChooseOut, .printerErrorIn,
    .printerOnlineIn, .printerBusyIn, .noMediaIn, .printerConfirmIn, .printerIrqLineIn,
    .printerIrqLineOut, .printerIrqLineOe, .muxSlotCode, .irqRequestIn, .processorResetRequest,
    .narrowBootFlag, .keyboardIrqFlag, .highAddressGate, .serialIrqIn, .muxSetOut0,
    .muxSetOut0Oe, .muxSetOut1, .muxSetOut1Oe);
  ppim_printer_model u_ppim_printer_model (.mclk, .latchPulse(printerLatchPulse),
    .chooseOut(printerChooseOut), .dataBus(printerDataBus), .paperOut, .slotSel,
    .errorIn(printerErrorIn), .onlineIn(printerOnlineIn), .busyIn(printerBusyIn), .noMediaIn,
    .confirmIn(printerConfirmIn), .slotCode(muxSlotCode), .gotByte);
  // ----------------------------------------------------------
  // clock, watchdog, helpers
  // ----------------------------------------------------------
  initial begin
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata  <= d;
    wstrb  <= 4'hF;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (!bvalid) @(posedge mclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a);
    @(posedge mclk);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rd   = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    axr(ppim_pkg::OFS_CTRL);
    chk("ctrl", rd, 32'h0);
    chk("setOe", {muxSetOut0Oe, muxSetOut1Oe}, 2'b11);
    axr(4'hC);
    chk("rresp", resp, ppim_pkg::RESP_SLVERR);
    axw(4'hC, 32'hFF);
    chk("bresp", resp, ppim_pkg::RESP_SLVERR);
    axw(ppim_pkg::OFS_DATA, 32'hA5);
    axw(ppim_pkg::OFS_CTRL, 32'h00E);
    repeat (2) @(posedge mclk);
    chk("ctl", {printerChooseOut, printerSetupRequest, autoLineAdvance, printerLatchPulse},
        4'hE);
    axw(ppim_pkg::OFS_CTRL, 32'h009);
    repeat (2) @(posedge mclk);
    chk("ctl", {printerChooseOut, printerSetupRequest, autoLineAdvance, printerLatchPulse},
        4'h9);
    chk("byte", gotByte, 8'hA5);
    repeat (30) @(posedge mclk);
    axr(ppim_pkg::OFS_STATUS);
    chk("stat", rd, 32'h32);
    repeat (50) @(posedge mclk);
    axr(ppim_pkg::OFS_STATUS);
    chk("stat", rd, 32'h02);
    axw(ppim_pkg::OFS_CTRL, 32'h028);
    axw(ppim_pkg::OFS_CTRL, 32'h029);
    repeat (80) @(posedge mclk);
    axr(ppim_pkg::OFS_STATUS);
    chk("stat", rd, 32'h22);
    axr(ppim_pkg::OFS_STATUS);
    chk("stat", rd, 32'h02);
    for (int s = 0; s < 16; s++) begin
      slotSel <= 3'(s % 8);
      v0 <= (s < 8) ? 8'h01 << (s % 8) : ~(8'h01 << (s % 8));
      v1 <= (s < 8) ? ~(8'h01 << (s % 8)) : 8'h01 << (s % 8);
      repeat (8) @(posedge mclk);
      chk("sets", {muxSetOut0, muxSetOut1}, (s < 8) ? 2'b10 : 2'b01);
    end
    v0 <= 8'h00;
    serialIrqIn <= 2'b01;
    axw(ppim_pkg::OFS_CTRL, 32'h0D8);
    repeat (3) @(posedge mclk);
    chk("alone", {printerIrqLineOe, printerIrqLineOut, muxSetOut0Oe, muxSetOut0, muxSetOut1Oe},
        5'b10110);
    axw(ppim_pkg::OFS_CTRL, 32'h0D9);
    repeat (40) @(posedge mclk);
    chk("irqOut", printerIrqLineOut, 1'b1);
    serialIrqIn <= 2'b10;
    axw(ppim_pkg::OFS_CTRL, 32'h148);
    repeat (3) @(posedge mclk);
    chk("alone", {printerIrqLineOe, muxSetOut0Oe, muxSetOut1Oe, muxSetOut1}, 4'b0011);
    // freeze: set output must hold while the clock enable is low
    mclkEn      <= 1'b0;
    serialIrqIn <= 2'b01;
    paperOut    <= 1'b1;
    repeat (12) @(posedge mclk);
    chk("frozen", muxSetOut1, 1'b1);
    mclkEn <= 1'b1;
    repeat (12) @(posedge mclk);
    chk("thawed", muxSetOut1, 1'b0);
    axr(ppim_pkg::OFS_STATUS);
    chk("stat", rd, 32'h0B);
    stop_test();
  end
endmodule : ppim_printer_port_tb_top
